// ---- rtl/roc_counters.sv ----
// Counters, control registers, pin decode and AXI4-Lite slave of the RC oscillation converter
// Contract
// - Decade counter on system clock, 0 to 79,999
// - 14-bit binary counter on oscillation clock, 0..16,383
// - Each counter overflow sets flag, may interrupt
// - Control 0 bit 1 picks interrupt source
// - Interrupt vector address is 02F hex
// - Control 0 bit 0 runs or halts conversion
// - Control 0 bit 2 powers both counters
// - Mode field codes 1-6 choose oscillating pair
// - Only selected pair drives; bit 3 floats all
// - Codes 0 and 7 count external inputs
// - Never enable both oscillation channels together
// - Oscillation clock can be routed to monitor pin
// - Counting starts after run plus start sync
// - Reference overflow clears run, stops, interrupts
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module roc_counters #(
  parameter int ADDR_W = 8
) (
  input  wire logic                          CLK,            // System clock, 10 MHz
  input  wire logic                          ARST_N,         // Asynchronous reset, active low
  input  wire logic [ADDR_W-1:0]             S_AXI_AWADDR,   // Write address
  input  wire logic                          S_AXI_AWVALID,  // Write address valid
  output logic                               S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0]                   S_AXI_WDATA,    // Write data
  input  wire logic [3:0]                    S_AXI_WSTRB,    // Write byte strobes
  input  wire logic                          S_AXI_WVALID,   // Write data valid
  output logic                               S_AXI_WREADY,   // Write data ready
  output logic [1:0]                         S_AXI_BRESP,    // Write response
  output logic                               S_AXI_BVALID,   // Write response valid
  input  wire logic                          S_AXI_BREADY,   // Write response ready
  input  wire logic [ADDR_W-1:0]             S_AXI_ARADDR,   // Read address
  input  wire logic                          S_AXI_ARVALID,  // Read address valid
  output logic                               S_AXI_ARREADY,  // Read address ready
  output logic [31:0]                        S_AXI_RDATA,    // Read data
  output logic [1:0]                         S_AXI_RRESP,    // Read response
  output logic                               S_AXI_RVALID,   // Read data valid
  input  wire logic                          S_AXI_RREADY,   // Read data ready
  input  wire logic                          RC_OSC_CLK,     // Raw clock from the RC oscillator
  input  wire logic                          EXT_IN_A,       // External clock input, channel 0
  input  wire logic                          EXT_IN_B,       // External clock input, channel 1
  output roc_pkg::roc_osc_pins_type          OSC_PINS,       // Oscillator pin drive and enables
  output roc_pkg::roc_osc_enable_type        OSC_ENABLE,     // Analog channel enables
  output logic                               MONITOR_OUT,    // Monitor pin level
  output logic                               MONITOR_OE,     // Monitor pin output enable
  output logic                               CONVERTER_IRQ,  // Interrupt request pulse
  output logic [11:0]                        VECTOR_ADDR     // Interrupt vector address
);

  typedef struct packed {
    logic                        aw_held;
    logic [7:0]                  awaddr;
    logic                        w_held;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic                        run;
    logic                        src;
    logic                        supply;
    logic [3:0]                  mode;
    logic                        monitor_en;
    logic [roc_pkg::DEC_W-1:0]   decade;
    logic [roc_pkg::BIN_W-1:0]   binary;
    logic                        dec_flag;
    logic                        bin_flag;
    roc_pkg::roc_phase_type      phase;
    logic                        osc_meta;
    logic                        osc_sync;
    logic                        osc_prev;
    roc_pkg::roc_osc_pins_type   pins;
    roc_pkg::roc_osc_enable_type osc_en;
    logic                        mon_out;
    logic                        mon_oe;
    logic                        irq;
    logic [11:0]                 vector;
  } roc_state_type;

  roc_state_type state_reg;
  roc_state_type state_next;

  logic       osc_select;
  logic       osc_edge;
  logic       counting;
  logic       dec_ovf;
  logic       bin_ovf;
  logic       ref_ovf;
  logic [19:0] dec_step_val;
  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] rd_addr;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 8 and 32");
  end

  // Returns {carry, next} for one BCD step that wraps from 79,999 to zero
  function automatic logic [19:0] dec_step(input logic [18:0] v);
    logic [18:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[i*4 +: 4] == roc_pkg::DEC_DIGIT_MAX) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    if (c) begin
      if (r[18:16] == roc_pkg::DEC_TOP_MAX) begin
        r[18:16] = 3'h0;
      end else begin
        r[18:16] = r[18:16] + 3'h1;
        c = 1'b0;
      end
    end
    return {c, r};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // External modes bypass the RC oscillator entirely
  // Mode bit 3 keeps the RC source, so an unavailable mode never counts an external input
  always_comb begin
    if (state_reg.mode[roc_pkg::MODE_OFF_BIT]) begin
      osc_select = RC_OSC_CLK;
    end else begin
      case (state_reg.mode[2:0])
        roc_pkg::MODE_EXT_A: osc_select = EXT_IN_A;
        roc_pkg::MODE_EXT_B: osc_select = EXT_IN_B;
        default:             osc_select = RC_OSC_CLK;
      endcase
    end
  end

  always_comb begin
    logic [31:0] merged;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;
    merged = 32'h0000_0000;
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    wr_ok  = 1'b1;
    state_next = state_reg;

    // The oscillation clock has no phase relation to CLK, so it is counted as sampled edges
    state_next.osc_meta = osc_select;
    state_next.osc_sync = state_reg.osc_meta;
    state_next.osc_prev = state_reg.osc_sync;
    osc_edge = state_reg.osc_sync & ~state_reg.osc_prev;

    counting     = (state_reg.phase == roc_pkg::PH_COUNTING);
    dec_step_val = dec_step(state_reg.decade);
    dec_ovf      = counting & dec_step_val[19];
    bin_ovf      = counting & osc_edge & (state_reg.binary == roc_pkg::BIN_MAX);
    ref_ovf      = state_reg.src ? bin_ovf : dec_ovf;

    if (counting) begin
      state_next.decade = dec_step_val[18:0];
      if (osc_edge) begin
        state_next.binary = state_reg.binary + 14'h0001;
      end
    end

    // Start is held back one cycle after run, standing in for the falling-edge start sync
    case (state_reg.phase)
      roc_pkg::PH_IDLE: begin
        if (state_reg.run && state_reg.supply) begin
          state_next.phase = roc_pkg::PH_ARMED;
        end
      end
      roc_pkg::PH_ARMED: begin
        if (!state_reg.run || !state_reg.supply) begin
          state_next.phase = roc_pkg::PH_IDLE;
        end else begin
          state_next.phase = roc_pkg::PH_COUNTING;
        end
      end
      roc_pkg::PH_COUNTING: begin
        if (!state_reg.run || !state_reg.supply || ref_ovf) begin
          state_next.phase = roc_pkg::PH_IDLE;
        end
      end
      default: state_next.phase = roc_pkg::PH_IDLE;
    endcase

    // AXI write channel: address and data are taken independently
    if (S_AXI_AWVALID && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr  = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata  = S_AXI_WDATA;
      state_next.wstrb  = S_AXI_WSTRB;
    end
    wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
    if (wr_fire) begin
      merged = merge(32'h0000_0000, state_reg.wdata, state_reg.wstrb);
      case (state_reg.awaddr)
        roc_pkg::OFF_CTRL0: begin
          if (state_reg.wstrb[0]) begin
            state_next.run    = merged[roc_pkg::CTRL0_RUN_BIT];
            state_next.src    = merged[roc_pkg::CTRL0_SRC_BIT];
            state_next.supply = merged[roc_pkg::CTRL0_SUPPLY_BIT];
          end
        end
        roc_pkg::OFF_MODE: begin
          if (state_reg.wstrb[0]) begin
            state_next.mode = merged[3:0];
          end
        end
        roc_pkg::OFF_DECADE: begin
          if (!state_reg.run) begin
            merged = merge({13'h0000, state_reg.decade}, state_reg.wdata, state_reg.wstrb);
            state_next.decade = merged[roc_pkg::DEC_W-1:0];
          end
        end
        roc_pkg::OFF_BINARY: begin
          if (!state_reg.run) begin
            merged = merge({18'h00000, state_reg.binary}, state_reg.wdata, state_reg.wstrb);
            state_next.binary = merged[roc_pkg::BIN_W-1:0];
          end
        end
        roc_pkg::OFF_STATUS: begin
          if (merged[roc_pkg::STATUS_DEC_OVF_BIT]) begin
            state_next.dec_flag = 1'b0;
          end
          if (merged[roc_pkg::STATUS_BIN_OVF_BIT]) begin
            state_next.bin_flag = 1'b0;
          end
        end
        roc_pkg::OFF_MONITOR: begin
          if (state_reg.wstrb[0]) begin
            state_next.monitor_en = merged[roc_pkg::MONITOR_EN_BIT];
          end
        end
        default: wr_ok = 1'b0;
      endcase
      state_next.bvalid = 1'b1;
      state_next.bresp  = wr_ok ? roc_pkg::RESP_OKAY : roc_pkg::RESP_SLVERR;
    end
    if (state_reg.bvalid && S_AXI_BREADY) begin
      state_next.bvalid  = 1'b0;
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
    end

    // Hardware events are applied after software, so a set beats a same-cycle clear
    if (dec_ovf) begin
      state_next.dec_flag = 1'b1;
    end
    if (bin_ovf) begin
      state_next.bin_flag = 1'b1;
    end
    if (ref_ovf) begin
      state_next.run = 1'b0;
    end
    state_next.irq    = ref_ovf;
    state_next.vector = roc_pkg::IRQ_VECTOR;

    // AXI read channel
    rd_fire = S_AXI_ARVALID & state_reg.arready;
    rd_addr = S_AXI_ARADDR[7:0];
    if (rd_fire) begin
      case (rd_addr)
        roc_pkg::OFF_CTRL0: begin
          rd_val[roc_pkg::CTRL0_RUN_BIT]    = state_reg.run;
          rd_val[roc_pkg::CTRL0_SRC_BIT]    = state_reg.src;
          rd_val[roc_pkg::CTRL0_SUPPLY_BIT] = state_reg.supply;
        end
        roc_pkg::OFF_MODE:    rd_val[3:0] = state_reg.mode;
        roc_pkg::OFF_DECADE:  rd_val[roc_pkg::DEC_W-1:0] = state_reg.decade;
        roc_pkg::OFF_BINARY:  rd_val[roc_pkg::BIN_W-1:0] = state_reg.binary;
        roc_pkg::OFF_STATUS: begin
          rd_val[roc_pkg::STATUS_DEC_OVF_BIT]  = state_reg.dec_flag;
          rd_val[roc_pkg::STATUS_BIN_OVF_BIT]  = state_reg.bin_flag;
          rd_val[roc_pkg::STATUS_COUNTING_BIT] = counting;
        end
        roc_pkg::OFF_MONITOR: rd_val[roc_pkg::MONITOR_EN_BIT] = state_reg.monitor_en;
        default:              rd_ok = 1'b0;
      endcase
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_val;
      state_next.rresp  = rd_ok ? roc_pkg::RESP_OKAY : roc_pkg::RESP_SLVERR;
    end else if (state_reg.rvalid && S_AXI_RREADY) begin
      state_next.rvalid = 1'b0;
    end
    state_next.awready = ~state_next.aw_held;
    state_next.wready  = ~state_next.w_held;
    state_next.arready = ~state_next.rvalid;

    // Pins float unless the oscillator runs; bit 3 of the mode floats every oscillator pin, while the monitor pin follows monitor_en
    state_next.pins   = '0;
    state_next.osc_en = '0;
    if (state_next.phase == roc_pkg::PH_COUNTING && !state_reg.mode[roc_pkg::MODE_OFF_BIT]) begin
      case (state_reg.mode[2:0])
        roc_pkg::MODE_RR_RC_A: begin
          state_next.osc_en.ch_zero = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_R_A] = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_C_A] = 1'b1;
          state_next.pins.out[roc_pkg::PIN_REF_R_A] = state_reg.osc_sync;
          state_next.pins.out[roc_pkg::PIN_REF_C_A] = ~state_reg.osc_sync;
        end
        roc_pkg::MODE_SR_RC_A: begin
          state_next.osc_en.ch_zero = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_SENS_R_A] = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_C_A]  = 1'b1;
          state_next.pins.out[roc_pkg::PIN_SENS_R_A] = state_reg.osc_sync;
          state_next.pins.out[roc_pkg::PIN_REF_C_A]  = ~state_reg.osc_sync;
        end
        roc_pkg::MODE_S2_RC_A: begin
          state_next.osc_en.ch_zero = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_SECOND_A] = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_C_A]  = 1'b1;
          state_next.pins.out[roc_pkg::PIN_SECOND_A] = state_reg.osc_sync;
          state_next.pins.out[roc_pkg::PIN_REF_C_A]  = ~state_reg.osc_sync;
        end
        roc_pkg::MODE_RR_SC_A: begin
          state_next.osc_en.ch_zero = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_R_A]  = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_SECOND_A] = 1'b1;
          state_next.pins.out[roc_pkg::PIN_REF_R_A]  = state_reg.osc_sync;
          state_next.pins.out[roc_pkg::PIN_SECOND_A] = ~state_reg.osc_sync;
        end
        roc_pkg::MODE_RR_C_B: begin
          state_next.osc_en.ch_one = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_REF_R_B]  = 1'b1;
          state_next.pins.out[roc_pkg::PIN_REF_R_B] = state_reg.osc_sync;
        end
        roc_pkg::MODE_SR_C_B: begin
          state_next.osc_en.ch_one = 1'b1;
          state_next.pins.oe[roc_pkg::PIN_SENS_R_B]  = 1'b1;
          state_next.pins.out[roc_pkg::PIN_SENS_R_B] = state_reg.osc_sync;
        end
        default: state_next.osc_en = '0;
      endcase
    end
    state_next.mon_oe  = state_reg.monitor_en;
    state_next.mon_out = state_reg.monitor_en & state_reg.osc_sync;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg        <= '0;
      state_reg.mode   <= roc_pkg::MODE_RESET;
      state_reg.vector <= roc_pkg::IRQ_VECTOR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign S_AXI_AWREADY = state_reg.awready;
  assign S_AXI_WREADY  = state_reg.wready;
  assign S_AXI_BVALID  = state_reg.bvalid;
  assign S_AXI_BRESP   = state_reg.bresp;
  assign S_AXI_ARREADY = state_reg.arready;
  assign S_AXI_RVALID  = state_reg.rvalid;
  assign S_AXI_RDATA   = state_reg.rdata;
  assign S_AXI_RRESP   = state_reg.rresp;
  assign OSC_PINS      = state_reg.pins;
  assign OSC_ENABLE    = state_reg.osc_en;
  assign MONITOR_OUT   = state_reg.mon_out;
  assign MONITOR_OE    = state_reg.mon_oe;
  assign CONVERTER_IRQ = state_reg.irq;
  assign VECTOR_ADDR   = state_reg.vector;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_ref_ovf_stop: assert property (ref_ovf |=> !state_reg.run && CONVERTER_IRQ
                                   ##1 state_reg.phase == roc_pkg::PH_IDLE)
    else $error("reference overflow did not stop and interrupt");
  a_irq_source: assert property (CONVERTER_IRQ |->
      (state_reg.src ? state_reg.bin_flag : state_reg.dec_flag))
    else $error("interrupt without the selected overflow flag");
  a_flag_sticky: assert property (dec_ovf |=> state_reg.dec_flag)
    else $error("decade overflow flag not set");
  a_channels_excl: assert property (!(OSC_ENABLE.ch_zero && OSC_ENABLE.ch_one))
    else $error("both oscillation channels enabled");
  a_mode_float: assert property (state_reg.mode[roc_pkg::MODE_OFF_BIT] |=> OSC_PINS.oe == '0)
    else $error("pins driven while mode bit 3 set");
  a_halt_frozen: assert property (!state_reg.run && state_reg.phase == roc_pkg::PH_IDLE
      && !wr_fire |=> $stable(state_reg.decade) && $stable(state_reg.binary))
    else $error("counter moved while halted");
  a_start_delay: assert property ($rose(state_reg.run) && state_reg.supply
      && state_reg.phase == roc_pkg::PH_IDLE |=> state_reg.phase == roc_pkg::PH_ARMED
      ##1 state_reg.phase == roc_pkg::PH_COUNTING || !state_reg.run)
    else $error("start sequence wrong");
  a_bin_count: assert property (counting && osc_edge && !bin_ovf |=>
      state_reg.binary == $past(state_reg.binary) + 14'h0001)
    else $error("binary counter missed an edge");
  a_dec_range: assert property (counting |-> state_reg.decade[3:0] <= roc_pkg::DEC_DIGIT_MAX
      || $past(wr_fire))
    else $error("decade digit out of range");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");

  c_dec_ref_done: cover property (CONVERTER_IRQ && !state_reg.src);
  c_bin_ref_done: cover property (CONVERTER_IRQ && state_reg.src);
  c_flag_race: cover property (wr_fire && dec_ovf && state_reg.awaddr == roc_pkg::OFF_STATUS);
  c_ext_mode: cover property (counting && osc_edge && state_reg.mode[2:0] == roc_pkg::MODE_EXT_B);

endmodule

// ---- rtl/roc_pkg.sv ----
// Package: register map, field positions, counts and carrier types of the RC oscillation counters
package roc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0   = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_DECADE  = 8'h08;
  localparam logic [7:0] OFF_BINARY  = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_MONITOR = 8'h14;

  // converter_control_0 fields
  localparam int         CTRL0_RUN_BIT    = 0;
  localparam int         CTRL0_SRC_BIT    = 1;
  localparam int         CTRL0_SUPPLY_BIT = 2;
  localparam logic [3:0] CTRL0_RESET      = 4'h0;

  // oscillation_mode_select fields
  localparam int         MODE_OFF_BIT = 3;
  localparam logic [3:0] MODE_RESET   = 4'h0;
  localparam logic [2:0] MODE_EXT_A   = 3'h0;
  localparam logic [2:0] MODE_RR_RC_A = 3'h1;
  localparam logic [2:0] MODE_SR_RC_A = 3'h2;
  localparam logic [2:0] MODE_S2_RC_A = 3'h3;
  localparam logic [2:0] MODE_RR_SC_A = 3'h4;
  localparam logic [2:0] MODE_RR_C_B  = 3'h5;
  localparam logic [2:0] MODE_SR_C_B  = 3'h6;
  localparam logic [2:0] MODE_EXT_B   = 3'h7;

  // Status and monitor fields
  localparam int STATUS_DEC_OVF_BIT  = 0;
  localparam int STATUS_BIN_OVF_BIT  = 1;
  localparam int STATUS_COUNTING_BIT = 2;
  localparam int MONITOR_EN_BIT      = 0;

  // Oscillator pin indices
  localparam int PIN_REF_R_A  = 0;
  localparam int PIN_SENS_R_A = 1;
  localparam int PIN_SECOND_A = 2;
  localparam int PIN_REF_C_A  = 3;
  localparam int PIN_REF_R_B  = 4;
  localparam int PIN_SENS_R_B = 5;
  localparam int OSC_PINS     = 6;

  // Counter limits: decade counter tops at 79,999, binary at 16,383
  localparam int          DEC_W        = 19;
  localparam logic [3:0]  DEC_DIGIT_MAX = 4'h9;
  localparam logic [2:0]  DEC_TOP_MAX   = 3'h7;
  localparam int          BIN_W        = 14;
  localparam logic [13:0] BIN_MAX      = 14'h3fff;

  localparam logic [11:0] IRQ_VECTOR = 12'h02f;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ARMED,
    PH_COUNTING
  } roc_phase_type;

  typedef struct packed {
    logic [OSC_PINS-1:0] out;
    logic [OSC_PINS-1:0] oe;
  } roc_osc_pins_type;

  typedef struct packed {
    logic ch_zero;
    logic ch_one;
  } roc_osc_enable_type;

endpackage

// ---- test/roc_osc_model.sv ----
// Far-side model: RC network oscillation and free-running external clock sources
`timescale 1ns/1ps
module roc_osc_model #(
  parameter int OSC_HALF_NS = 400,
  parameter int EXT_HALF_NS = 500
) (
  input  roc_pkg::roc_osc_enable_type enable,  // Analog channel enables
  output logic                        rc_clk,  // Oscillation clock
  output logic                        ext_a,   // External clock, channel 0
  output logic                        ext_b    // External clock, channel 1
);
  initial begin
    rc_clk = 1'b0;
    ext_a  = 1'b0;
    ext_b  = 1'b0;
  end
  // The network only oscillates while a channel is powered; it stands low otherwise
  always #(OSC_HALF_NS) rc_clk = (enable.ch_zero | enable.ch_one) ? ~rc_clk : 1'b0;
  always #(EXT_HALF_NS) ext_a = ~ext_a;
  // Different period so the two external inputs can be told apart
  always #(EXT_HALF_NS + 100) ext_b = ~ext_b;
endmodule

// ---- test/test_rc_oscillation_adc_counters.sv ----
// Bench: register access, every oscillation mode and both reference modes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_rc_oscillation_adc_counters;
  logic                        clk, arst_n, awvalid, wvalid, arvalid, awready, wready;
  logic                        bvalid, arready, rvalid, irq, mon_out, mon_oe, rc_clk, ext_a, ext_b;
  logic [7:0]                  awaddr, araddr;
  logic [31:0]                 wdata, rdata, d;
  logic [1:0]                  bresp, rresp, r;
  logic [11:0]                 vec;
  roc_pkg::roc_osc_pins_type   pins;
  roc_pkg::roc_osc_enable_type en;
  int                          fail_count, num_checks;
  logic [5:0] oe_tab [9] = '{6'h00, 6'h09, 6'h0a, 6'h0c, 6'h05, 6'h10, 6'h20, 6'h00, 6'h00};
  logic [1:0] en_tab [9] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};

  roc_counters DUT (
    .CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .RC_OSC_CLK(rc_clk), .EXT_IN_A(ext_a), .EXT_IN_B(ext_b), .OSC_PINS(pins),
    .OSC_ENABLE(en), .MONITOR_OUT(mon_out), .MONITOR_OE(mon_oe), .CONVERTER_IRQ(irq),
    .VECTOR_ADDR(vec)
  );
  roc_osc_model PEER (.enable(en), .rc_clk(rc_clk), .ext_a(ext_a), .ext_b(ext_b));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A response code the slave can never give marks a bus hang
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    r = bvalid ? bresp : 2'h1;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rvalid ? rresp : 2'h1;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    `CHK("bresp", roc_pkg::RESP_OKAY, r)
  endtask

  task automatic conv(input logic [3:0] m, input logic src, input logic [31:0] dv, bv);
    w(roc_pkg::OFF_DECADE, dv);
    w(roc_pkg::OFF_BINARY, bv);
    w(roc_pkg::OFF_MODE, {28'h0, m});
    w(roc_pkg::OFF_CTRL0, 32'h4); // Supply on first
    repeat (1200) @(posedge clk); // 1200 system clock periods, 120 us
    w(roc_pkg::OFF_CTRL0, {29'h0, 1'b1, src, 1'b1}); // Supply stays on while run rises
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!irq && n < 20000);
    `CHK("irq", 1'b1, irq)
    @(posedge clk);
    `CHK("irq_pulse", 1'b0, irq)
  endtask

  task wrap_up;
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #4000000;
    fail_count++;
    wrap_up;
  end

  initial begin
    arst_n <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    arvalid <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("vector", 12'h02f, vec)
    rd(roc_pkg::OFF_CTRL0);
    `CHK("ctrl0_rst", 32'h0, d)
    rd(roc_pkg::OFF_MODE);
    `CHK("mode_rst", 32'h0, d)
    rd(8'h20);
    `CHK("unmapped_rd", {32'h0, roc_pkg::RESP_SLVERR}, {d, r})
    wr(8'h20, 32'h5);
    `CHK("unmapped_wr", roc_pkg::RESP_SLVERR, r)
    w(roc_pkg::OFF_MONITOR, 32'h1);
    for (int m = 0; m < 9; m++) begin
      conv(m[3:0], 1'b0, 32'h79800, 32'h0); // Gate of 200 cycles
      repeat (60) @(posedge clk);
      `CHK("pin_oe", oe_tab[m], pins.oe)
      `CHK("chan_en", en_tab[m], en)
      `CHK("monitor_oe", 1'b1, mon_oe)
      if (m == 5) `CHK("monitor_out", pins.out[roc_pkg::PIN_REF_R_B], mon_out)
      if (m > 0 && m < 5) `CHK("pair", 1'b1, ^(pins.out & oe_tab[m]))
      w(roc_pkg::OFF_BINARY, 32'h1234); // Must be ignored mid-run
      wait_irq;
      rd(roc_pkg::OFF_CTRL0);
      `CHK("run_clear", 32'h4, d)
      rd(roc_pkg::OFF_STATUS);
      `CHK("status", 32'h1, d)
      rd(roc_pkg::OFF_BINARY);
      `CHK("bin_count", m != 8, d >= 12 && d <= 30)
      rd(roc_pkg::OFF_DECADE);
      `CHK("dec_wrap", 32'h0, d)
      w(roc_pkg::OFF_STATUS, 32'h3);
    end
    conv(4'h5, 1'b1, 32'h0, 32'h3ff6); // Gate of ten oscillation periods
    wait_irq;
    rd(roc_pkg::OFF_CTRL0);
    `CHK("run_clear_b", 32'h6, d)
    rd(roc_pkg::OFF_STATUS);
    `CHK("status_b", 32'h2, d)
    rd(roc_pkg::OFF_BINARY);
    `CHK("bin_wrap", 32'h0, d)
    rd(roc_pkg::OFF_DECADE);
    `CHK("dec_count", 1'b1, d >= 32'h60 && d <= 32'h99)
    wrap_up;
  end
endmodule
